// File: tb/qcd_enc_model.sv
// Behavioural mechanical encoder with bouncing contacts and pushbutton.
`timescale 1ns/10ps
module qcd_enc_model (
   input wire logic i_ref_clk,
   output logic o_a,
   output logic o_b,
   output logic o_btn
);
   // Open contacts read high through the pull-ups.
   initial begin
      o_a = 1'h1;
      o_b = 1'h1;
      o_btn = 1'h1;
   end

   // Moves to a new phase code, bouncing nb times for under four samples.
   task automatic step(input logic [1:0] ph, input int nb);
      logic [1:0] old;
      old = {o_a, o_b};
      for (int k = 0; k < nb; k++) begin
         @(posedge i_ref_clk);
         {o_a, o_b} <= ph;
         repeat ($urandom_range(0, 2)) @(posedge i_ref_clk);
         @(posedge i_ref_clk);
         {o_a, o_b} <= old;
      end
      @(posedge i_ref_clk);
      {o_a, o_b} <= ph;
      repeat (8) @(posedge i_ref_clk);
   endtask : step

   // Presses or releases the button, bouncing for under ten samples.
   task automatic push(input logic lvl, input int nb);
      for (int k = 0; k < nb; k++) begin
         @(posedge i_ref_clk);
         o_btn <= lvl;
         repeat ($urandom_range(0, 7)) @(posedge i_ref_clk);
         @(posedge i_ref_clk);
         o_btn <= ~lvl;
      end
      @(posedge i_ref_clk);
      o_btn <= lvl;
      repeat (15) @(posedge i_ref_clk);
   endtask : push
endmodule : qcd_enc_model

// File: tb/tb_top.sv
// Self-checking bench for the encoder click decoder.
`timescale 1ns/10ps
module tb_top;
   import qcd_pkg::*;
   localparam int unsigned W_CYC = 20;
   localparam int unsigned LEAD_CYC = 3;
   logic i_ref_clk = 1'h0;
   logic i_rst_b = 1'h0;
   logic i_clk_en = 1'h1;
   logic enc_a;
   logic enc_b;
   logic btn;
   logic o_dir;
   logic o_strobe;
   logic o_button_clean_out;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   int wcnt = 0;
   int dir_chg = 0;
   logic exp_dir_q[$];
   logic exp_btn_q[$];
   logic dir_p = 1'h0;
   logic stb_p = 1'h0;
   logic btn_p = 1'h1;
   logic last_dir = 1'h0;
   logic dir_e;
   logic btn_e;
   qcd_phase_t cw_seq[4] = '{QCD_PH_01, QCD_PH_00, QCD_PH_10, QCD_PH_11};
   qcd_phase_t ccw_seq[4] = '{QCD_PH_10, QCD_PH_00, QCD_PH_01, QCD_PH_11};

   always #2.5 i_ref_clk = ~i_ref_clk;

   qcd_enc_model i_enc (
      .i_ref_clk(i_ref_clk),
      .o_a(enc_a),
      .o_b(enc_b),
      .o_btn(btn)
   );

   qcd_top #(
      .STROBE_WIDTH_CYC(W_CYC),
      .BTN_CLEAN_CYC(10),
      .PHASE_STABLE_CYC(4),
      .DIR_DELAY_CYC(LEAD_CYC)
   ) i_dut (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_enc_a(enc_a),
      .i_enc_b(enc_b),
      .i_button_raw_in(btn),
      .o_dir(o_dir),
      .o_strobe(o_strobe),
      .o_button_clean_out(o_button_clean_out)
   );

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk_num

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   // One full detent in the given direction, then a quiet spell.
   task automatic click(input logic dir, input int nb);
      exp_dir_q.push_back(dir);
      for (int k = 0; k < 4; k++) begin
         i_enc.step(dir ? ccw_seq[k] : cw_seq[k], nb);
      end
      repeat (40) @(posedge i_ref_clk);
   endtask : click

   task automatic press(input logic lvl, input int nb);
      exp_btn_q.push_back(lvl);
      i_enc.push(lvl, nb);
      repeat (20) @(posedge i_ref_clk);
   endtask : press

   // Watches the outputs and pairs each event with the oldest note.
   always @(posedge i_ref_clk) begin
      cyc++;
      if (i_rst_b) begin
         if (o_dir !== dir_p) begin
            dir_chg = cyc;
            dir_e = exp_dir_q.size() > 0 ? exp_dir_q[0] : dir_p;
            chk_bit(o_dir, dir_e);
         end
         if (o_strobe && !stb_p) begin
            if (exp_dir_q.size() == 0) begin
               chk_bit(o_strobe, 1'h0);
            end else begin
               chk_bit(o_dir, exp_dir_q.pop_front());
               if (o_dir !== last_dir) begin
                  chk_num(cyc - dir_chg, LEAD_CYC);
               end
               last_dir = o_dir;
            end
            wcnt = 0;
         end
         // Only enabled cycles count towards the pulse width.
         if (o_strobe && i_clk_en) begin
            wcnt++;
         end
         if (!o_strobe && stb_p) begin
            chk_num(wcnt, W_CYC);
         end
         if (o_button_clean_out !== btn_p) begin
            btn_e = exp_btn_q.size() > 0 ? exp_btn_q.pop_front() : btn_p;
            chk_bit(o_button_clean_out, btn_e);
         end
      end else begin
         last_dir = QCD_DIR_CW;
      end
      dir_p = o_dir;
      stb_p = o_strobe;
      btn_p = o_button_clean_out;
   end

   initial begin
      wait (cyc >= 20000);
      n_fail++;
      wrap_up();
   end

   initial begin
      void'($urandom(32'h8affc5c5));
      repeat (6) @(posedge i_ref_clk);
      i_rst_b <= 1'h1;
      @(posedge i_ref_clk);
      chk_bit(o_dir, QCD_DIR_CW);
      chk_bit(o_strobe, 1'h0);
      chk_bit(o_button_clean_out, QCD_OPEN_LEVEL);
      click(QCD_DIR_CW, 3);
      click(QCD_DIR_CCW, 3);
      click(QCD_DIR_CCW, 0);
      // A half step that returns to rest gives no click.
      i_enc.step(QCD_PH_10, 2);
      i_enc.step(QCD_PH_11, 2);
      repeat (40) @(posedge i_ref_clk);
      // Backward steps inside a clockwise detent still count once.
      exp_dir_q.push_back(QCD_DIR_CW);
      i_enc.step(QCD_PH_01, 1);
      i_enc.step(QCD_PH_00, 1);
      i_enc.step(QCD_PH_01, 1);
      i_enc.step(QCD_PH_00, 1);
      i_enc.step(QCD_PH_10, 1);
      i_enc.step(QCD_PH_11, 1);
      repeat (40) @(posedge i_ref_clk);
      press(1'h0, 3);
      press(1'h1, 2);
      // A freeze in mid-pulse stretches the strobe but not its count.
      fork
         click(QCD_DIR_CW, 1);
         begin
            @(posedge o_strobe);
            repeat (3) @(posedge i_ref_clk);
            i_clk_en <= 1'h0;
            repeat (5) @(posedge i_ref_clk);
            i_clk_en <= 1'h1;
         end
      join
      for (int i = 0; i < 16; i++) begin
         click(1'($urandom_range(0, 1)), $urandom_range(0, 4));
      end
      click(QCD_DIR_CCW, 1);
      chk_num(exp_dir_q.size(), 0);
      chk_num(exp_btn_q.size(), 0);
      // A reset in mid-run brings the direction back to clockwise.
      i_rst_b <= 1'h0;
      @(posedge i_ref_clk);
      chk_bit(o_dir, QCD_DIR_CW);
      chk_bit(o_strobe, 1'h0);
      repeat (2) @(posedge i_ref_clk);
      i_rst_b <= 1'h1;
      click(QCD_DIR_CW, 2);
      chk_num(exp_dir_q.size(), 0);
      wrap_up();
   end
endmodule : tb_top

// File: verilog/qcd_filter.sv
// Stability filter: the output takes a new level only after it holds.
`timescale 1ns/10ps
module qcd_filter
   import qcd_pkg::*;
#(
   parameter int unsigned STABLE_CYC = QCD_PHASE_STABLE_CYC,
   parameter logic RST_VAL = QCD_OPEN_LEVEL
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic i_level,
   output logic o_level
);

   logic level_q;
   logic level_d;
   qcd_cnt_t cnt_q;
   qcd_cnt_t cnt_d;
   logic differs_w;
   logic settled_w;

   // Any sample back at the held level restarts the count, so bounce that
   // stays away for fewer than STABLE_CYC samples never reaches the output.
   assign differs_w = i_level != level_q;
   assign settled_w = cnt_q == QCD_CNT_W'(STABLE_CYC - 1);
   assign cnt_d = (!differs_w || settled_w) ? '0 : cnt_q + 1'b1;
   assign level_d = (differs_w && settled_w) ? i_level : level_q;
   assign o_level = level_q;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         level_q <= RST_VAL;
         cnt_q <= '0;
      end else if (i_clk_en) begin
         level_q <= level_d;
         cnt_q <= cnt_d;
      end
   end

   property p_settle;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $changed(level_q) |->
         $past(cnt_q) == QCD_CNT_W'(STABLE_CYC - 1) && $past(differs_w);
   endproperty
   a_settle: assert property (p_settle)
      else $error("Filtered level changed before the input settled.");

endmodule : qcd_filter

// File: verilog/qcd_pkg.sv
// Shared constants, carriers and state types of the encoder click decoder.
package qcd_pkg;

   // Clock rate and counter width.
   localparam int unsigned QCD_CLK_HZ = 200_000_000;
   localparam int unsigned QCD_CNT_W = 32;
   typedef logic [QCD_CNT_W-1:0] qcd_cnt_t;

   // Times in their own units, then cycle counts derived from the clock.
   localparam int unsigned QCD_DIR_DELAY_NS = 2000;
   localparam int unsigned QCD_STROBE_WIDTH_MS = 5;
   localparam int unsigned QCD_BTN_CLEAN_MS = 20;
   localparam int unsigned QCD_PHASE_STABLE_US = 500;
   localparam int unsigned QCD_CYC_PER_US = QCD_CLK_HZ / 1_000_000;
   localparam int unsigned QCD_CYC_PER_MS = QCD_CLK_HZ / 1_000;
   localparam int unsigned QCD_DIR_DELAY_CYC =
      (QCD_CYC_PER_US * QCD_DIR_DELAY_NS + 999) / 1000;
   localparam int unsigned QCD_STROBE_WIDTH_CYC =
      QCD_CYC_PER_MS * QCD_STROBE_WIDTH_MS;
   localparam int unsigned QCD_BTN_CLEAN_CYC =
      QCD_CYC_PER_MS * QCD_BTN_CLEAN_MS;
   localparam int unsigned QCD_PHASE_STABLE_CYC =
      QCD_CYC_PER_US * QCD_PHASE_STABLE_US;

   // Level that an open, internally pulled-up switch reads.
   localparam logic QCD_OPEN_LEVEL = 1'h1;

   // Phase codes, A in the upper bit and B in the lower.
   typedef struct packed {
      logic a;
      logic b;
   } qcd_phase_t;
   localparam qcd_phase_t QCD_PH_11 = 2'h3;
   localparam qcd_phase_t QCD_PH_01 = 2'h1;
   localparam qcd_phase_t QCD_PH_00 = 2'h0;
   localparam qcd_phase_t QCD_PH_10 = 2'h2;

   // Direction codes.
   localparam logic QCD_DIR_CW = 1'h0;
   localparam logic QCD_DIR_CCW = 1'h1;

   // Registered outputs of the click path.
   typedef struct packed {
      logic dir;
      logic strobe;
   } qcd_click_t;
   localparam qcd_click_t QCD_CLICK_RST = 2'h0;

   typedef enum logic [2:0] {
      DEC_IDLE, DEC_CW1, DEC_CW2, DEC_CW3, DEC_CCW1, DEC_CCW2, DEC_CCW3
   } qcd_dec_t;

   typedef enum logic [1:0] {
      OS_IDLE, OS_DELAY, OS_PULSE, OS_GAP
   } qcd_out_st_t;

endpackage : qcd_pkg

// File: verilog/qcd_timer.sv
// Loadable down-counter that flags the last cycle of an interval.
`timescale 1ns/10ps
module qcd_timer
   import qcd_pkg::*;
#(
   parameter int unsigned W = QCD_CNT_W
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic i_load,
   input wire logic [W-1:0] i_count,
   output logic o_busy,
   output logic o_done
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic busy_q;
   logic busy_d;

   // A load lasts i_count cycles; o_done is high in the last of them.
   // A load in the done cycle wins and starts the next interval.
   assign o_done = busy_q && (cnt_q == '0);
   assign o_busy = busy_q;
   assign cnt_d = i_load ? i_count - 1'b1 :
                  (busy_q && !o_done) ? cnt_q - 1'b1 : cnt_q;
   assign busy_d = i_load ? 1'b1 : (o_done ? 1'b0 : busy_q);

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
      end else if (i_clk_en) begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
      end
   end

endmodule : qcd_timer

// File: verilog/qcd_top.sv
// Encoder click decoder with debounced phases and pushbutton.
`timescale 1ns/10ps
module qcd_top
   import qcd_pkg::*;
#(
   parameter int unsigned STROBE_WIDTH_CYC = QCD_STROBE_WIDTH_CYC,
   parameter int unsigned BTN_CLEAN_CYC = QCD_BTN_CLEAN_CYC,
   parameter int unsigned PHASE_STABLE_CYC = QCD_PHASE_STABLE_CYC,
   parameter int unsigned DIR_DELAY_CYC = QCD_DIR_DELAY_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic i_enc_a,
   input wire logic i_enc_b,
   input wire logic i_button_raw_in,
   output logic o_dir,
   output logic o_strobe,
   output logic o_button_clean_out
);

   // Next decoder state from the current state and filtered phases.
   // A step backwards inside a click is followed, so a knob that is
   // wiggled mid-detent still completes cleanly; a skipped code is held, except 11, which always returns to rest.
   function automatic qcd_dec_t dec_next(qcd_dec_t s, qcd_phase_t p);
      qcd_dec_t n;
      n = s;
      if (p == QCD_PH_11) begin
         n = DEC_IDLE;
      end else begin
         case (s)
            DEC_IDLE: begin
               if (p == QCD_PH_01) begin
                  n = DEC_CW1;
               end else if (p == QCD_PH_10) begin
                  n = DEC_CCW1;
               end
            end
            DEC_CW1: begin
               if (p == QCD_PH_00) begin
                  n = DEC_CW2;
               end
            end
            DEC_CW2: begin
               if (p == QCD_PH_10) begin
                  n = DEC_CW3;
               end else if (p == QCD_PH_01) begin
                  n = DEC_CW1;
               end
            end
            DEC_CW3: begin
               if (p == QCD_PH_00) begin
                  n = DEC_CW2;
               end
            end
            DEC_CCW1: begin
               if (p == QCD_PH_00) begin
                  n = DEC_CCW2;
               end
            end
            DEC_CCW2: begin
               if (p == QCD_PH_01) begin
                  n = DEC_CCW3;
               end else if (p == QCD_PH_10) begin
                  n = DEC_CCW1;
               end
            end
            DEC_CCW3: begin
               if (p == QCD_PH_00) begin
                  n = DEC_CCW2;
               end
            end
            default: begin
               n = DEC_IDLE;
            end
         endcase
      end
      return n;
   endfunction : dec_next

   qcd_phase_t ph_w;
   qcd_dec_t dec_q;
   qcd_dec_t dec_d;
   logic click_w;
   logic click_dir_w;
   logic pend_q;
   logic pend_d;
   logic pend_dir_q;
   logic pend_dir_d;
   qcd_out_st_t out_q;
   qcd_out_st_t out_d;
   qcd_click_t clk_q;
   qcd_click_t clk_d;
   logic take_w;
   logic rev_w;
   logic start_pulse_w;
   logic end_pulse_w;
   logic tmr_load_w;
   qcd_cnt_t tmr_count_w;
   logic tmr_done_w;
   logic btn_level_w;

   // The decoder sees only the filtered phase levels.
   qcd_filter #(
      .STABLE_CYC(PHASE_STABLE_CYC),
      .RST_VAL(QCD_OPEN_LEVEL)
   ) u_filt_a (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_level(i_enc_a),
      .o_level(ph_w.a)
   );

   qcd_filter #(
      .STABLE_CYC(PHASE_STABLE_CYC),
      .RST_VAL(QCD_OPEN_LEVEL)
   ) u_filt_b (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_level(i_enc_b),
      .o_level(ph_w.b)
   );

   qcd_filter #(
      .STABLE_CYC(BTN_CLEAN_CYC),
      .RST_VAL(QCD_OPEN_LEVEL)
   ) u_filt_btn (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_level(i_button_raw_in),
      .o_level(btn_level_w)
   );

   // The pressed button pulls its input low, so the level passes as is.
   assign o_button_clean_out = btn_level_w;

   // Decoder and click detection.
   assign dec_d = dec_next(dec_q, ph_w);
   assign click_w = ((dec_q == DEC_CW3) || (dec_q == DEC_CCW3)) &&
                    (ph_w == QCD_PH_11);
   assign click_dir_w = (dec_q == DEC_CCW3) ? QCD_DIR_CCW :
                        QCD_DIR_CW;

   // One click may wait while a pulse is in progress; a new click wins
   // over the take in the same cycle, so it is not dropped.
   assign take_w = (out_q == OS_IDLE) && pend_q;
   assign pend_d = click_w ? 1'b1 : (take_w ? 1'b0 : pend_q);
   assign pend_dir_d = click_w ? click_dir_w : pend_dir_q;

   // Output sequencing.
   assign rev_w = pend_dir_q != clk_q.dir;
   assign start_pulse_w = (take_w && !rev_w) ||
                          ((out_q == OS_DELAY) && tmr_done_w);
   assign end_pulse_w = (out_q == OS_PULSE) && tmr_done_w;
   assign tmr_load_w = take_w || ((out_q == OS_DELAY) && tmr_done_w) ||
                       end_pulse_w;
   assign tmr_count_w = start_pulse_w ? QCD_CNT_W'(STROBE_WIDTH_CYC) :
                        QCD_CNT_W'(DIR_DELAY_CYC);

   assign clk_d.dir = (take_w && rev_w) ? pend_dir_q : clk_q.dir;
   assign clk_d.strobe = start_pulse_w ? 1'b1 :
                         (end_pulse_w ? 1'b0 : clk_q.strobe);
   assign o_dir = clk_q.dir;
   assign o_strobe = clk_q.strobe;

   always_comb begin
      out_d = out_q;
      case (out_q)
         OS_IDLE: begin
            if (take_w) begin
               out_d = rev_w ? OS_DELAY : OS_PULSE;
            end
         end
         OS_DELAY: begin
            if (tmr_done_w) begin
               out_d = OS_PULSE;
            end
         end
         OS_PULSE: begin
            if (tmr_done_w) begin
               out_d = OS_GAP;
            end
         end
         OS_GAP: begin
            if (tmr_done_w) begin
               out_d = OS_IDLE;
            end
         end
         default: begin
            out_d = OS_IDLE;
         end
      endcase
   end

   // The same timer measures the lead, the pulse and the low gap.
   qcd_timer #(
      .W(QCD_CNT_W)
   ) u_timer (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_load(tmr_load_w),
      .i_count(tmr_count_w),
      .o_busy(),
      .o_done(tmr_done_w)
   );

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dec_q <= DEC_IDLE;
         pend_q <= 1'b0;
         pend_dir_q <= QCD_DIR_CW;
         out_q <= OS_IDLE;
         clk_q <= QCD_CLICK_RST;
      end else if (i_clk_en) begin
         dec_q <= dec_d;
         pend_q <= pend_d;
         pend_dir_q <= pend_dir_d;
         out_q <= out_d;
         clk_q <= clk_d;
      end
   end

   // Cycles since the last direction change and length of the pulse.
   logic [15:0] since_dir_q;
   qcd_cnt_t hi_cnt_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         since_dir_q <= '0;
         hi_cnt_q <= '0;
      end else if (i_clk_en) begin
         if (clk_d.dir != clk_q.dir) begin
            since_dir_q <= '0;
         end else if (since_dir_q != 16'hFFFF) begin
            since_dir_q <= since_dir_q + 16'h0001;
         end
         hi_cnt_q <= clk_q.strobe ? hi_cnt_q + 1'b1 : '0;
      end
   end

   property p_rest;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_clk_en && ph_w == QCD_PH_11 |=> dec_q == DEC_IDLE;
   endproperty
   a_rest: assert property (p_rest)
      else $error("Decoder left rest while both phases were high.");

   property p_cw;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_clk_en && dec_q == DEC_CW3 && ph_w == QCD_PH_11 |=>
         pend_q && pend_dir_q == QCD_DIR_CW && dec_q == DEC_IDLE;
   endproperty
   a_cw: assert property (p_cw)
      else $error("Clockwise click was not recognised.");

   property p_ccw;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_clk_en && dec_q == DEC_CCW3 && ph_w == QCD_PH_11 |=>
         pend_q && pend_dir_q == QCD_DIR_CCW && dec_q == DEC_IDLE;
   endproperty
   a_ccw: assert property (p_ccw)
      else $error("Anticlockwise click was not recognised.");

   property p_reset_low;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(i_rst_b) |-> !o_strobe && o_dir == QCD_DIR_CW;
   endproperty
   a_reset_low: assert property (p_reset_low)
      else $error("Outputs not low after reset.");

   property p_pulse_cause;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(o_strobe) |-> $past(start_pulse_w) && out_q == OS_PULSE;
   endproperty
   a_pulse_cause: assert property (p_pulse_cause)
      else $error("Strobe rose without a pending click.");

   property p_dir_code;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_clk_en && take_w && rev_w |=> o_dir == $past(pend_dir_q) && !o_strobe;
   endproperty
   a_dir_code: assert property (p_dir_code)
      else $error("Direction does not show the click direction.");

   property p_quiet;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      !click_w && !pend_q && out_q == OS_IDLE |=> !o_strobe && $stable(o_dir);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("Outputs moved without a completed click.");

   property p_dir_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $changed(o_dir) |-> $past(take_w && rev_w);
   endproperty
   a_dir_hold: assert property (p_dir_hold)
      else $error("Direction changed without an opposite click.");

   property p_lead;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(o_strobe) && $past(out_q) == OS_DELAY |->
         since_dir_q == 16'(DIR_DELAY_CYC);
   endproperty
   a_lead: assert property (p_lead)
      else $error("Strobe did not trail the direction change correctly.");

   property p_width;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $fell(o_strobe) |-> hi_cnt_q == QCD_CNT_W'(STROBE_WIDTH_CYC);
   endproperty
   a_width: assert property (p_width)
      else $error("Strobe pulse has the wrong width.");

endmodule : qcd_top
